/* File: chan_reg_file.sv */
/*
  Byte register file of one channel, registered read.
  Assumes same-clock writes and addresses.
*/
`timescale 1ns/10ps
`default_nettype none
`include "usb_ctrl_cfg.svh"

module chan_reg_file #(
  parameter int ADDR_W = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [ADDR_W-1:0] raddr_i,
  output logic [7:0] rdata_o,
  output logic tx_en_o,
  output logic rx_en_o
);

  typedef struct packed {
    logic [(1<<ADDR_W)-1:0][7:0] mem;
    logic [7:0] rdata;
  } chan_state_t;

  chan_state_t q, d;

  // write, registered read
  always_comb begin
    d = q;
    if (we_i) begin
      d.mem[waddr_i] = wdata_i;
      if (waddr_i == `OFF_UART_ENABLE) begin
        d.mem[waddr_i] = {6'h00, wdata_i[1:0]}; // reserved bits stay zero
      end
    end
    d.rdata = q.mem[raddr_i];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign tx_en_o = q.mem[`OFF_UART_ENABLE][`UART_EN_TX_BIT];
  assign rx_en_o = q.mem[`OFF_UART_ENABLE][`UART_EN_RX_BIT];

endmodule // chan_reg_file

`default_nettype wire

/* File: tb_top.sv */
/*
  Self-checking bench for usb_ctrl_regs via the host model.
  Assumes design, package and model compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import usb_ctrl_pkg::*;
  logic clk_i, rst_i, setup_valid_i, out_valid_i, in_ready_i, self_powered_i, ee_ack_i;
  logic [7:0] request_type_i, request_i, out_data_i, ee_rdata_i, in_data_o, ee_addr_o, ee_wdata_o;
  logic [15:0] value_i, index_i, length_i;
  logic in_valid_o, in_last_o, status_ack_o, stall_o, ee_req_o, ee_we_o;
  logic [1:0] fifo_tx_en_o, fifo_rx_en_o, rx_flush_o, tx_flush_o, uart_tx_en_o, uart_rx_en_o, break_req_o;
  line_coding_t [1:0] line_coding_o;
  logic [1:0][1:0] modem_ctrl_o;
  logic [1:0][15:0] break_duration_o;
  logic [5:0] ev;
  int err_count, total_checks, cyc;
  logic [7:0] fl [4] = '{8'h18, 8'h19, 8'h1C, 8'h1D};
  logic [31:0] bad [4] = '{32'h4000_0700, 32'h4100_0000, 32'h2122_0001, 32'h8006_0000};
  logic [7:0] lc [7] = '{8'hB0, 8'h04, 8'h00, 8'h00, 8'h01, 8'h02, 8'h07};
  logic [7:0] lr [7] = '{8'h80, 8'h25, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08};
  usb_ctrl_regs i_usb_ctrl_regs (.clk_i, .rst_i, .setup_valid_i, .request_type_i, .request_i, .value_i,
    .index_i, .length_i, .out_valid_i, .out_data_i, .in_ready_i, .self_powered_i, .ee_ack_i, .ee_rdata_i,
    .in_valid_o, .in_data_o, .in_last_o, .status_ack_o, .stall_o, .ee_req_o, .ee_we_o, .ee_addr_o, .ee_wdata_o,
    .fifo_tx_en_o, .fifo_rx_en_o, .rx_flush_o, .tx_flush_o, .uart_tx_en_o, .uart_rx_en_o, .line_coding_o,
    .modem_ctrl_o, .break_req_o, .break_duration_o, .wide_mode_o(), .low_latency_o(), .int_packet_o(),
    .remote_wake_en_o(), .usb_address_o(), .configuration_o(), .ep_halt_o(), .test_selector_o());
  usb_host_model i_host (.clk_i, .setup_valid_o(setup_valid_i), .request_type_o(request_type_i),
    .request_o(request_i), .value_o(value_i), .index_o(index_i), .length_o(length_i), .out_valid_o(out_valid_i),
    .out_data_o(out_data_i), .in_ready_o(in_ready_i), .in_valid_i(in_valid_o), .in_data_i(in_data_o));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // sticky pulse record
  always @(posedge clk_i) ev <= ev | {stall_o, status_ack_o, tx_flush_o, rx_flush_o};
  // eeprom answers a cycle after request
  always @(negedge clk_i) begin
    ee_ack_i = ee_req_o && !ee_ack_i;
    ee_rdata_i = ee_ack_i ? 8'h5A : 8'hA5;
  end
  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [63:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // setup, n reply bytes, wait for ack or stall
  task automatic req(input logic [7:0] t, r, input logic [15:0] v, i, l, input int n, s);
    int k;
    ev = '0;
    i_host.setup(t, r, v, i, l);
    i_host.take(n, s);
    k = 0;
    while (ev[5:4] == 2'b00 && k < 30) begin
      @(negedge clk_i);
      k++;
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    {rst_i, self_powered_i, ee_ack_i, ee_rdata_i, ev, cyc, err_count, total_checks} = {3'b110, 8'hA5, 6'h0, 96'h0};
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    // channel a bring-up, channel b rx only
    req(8'h40, 8'h00, 16'h0001, 16'h0410, 16'h0, 0, 0);
    check({ev[4], fifo_rx_en_o[0], fifo_tx_en_o[0]}, 3'b101);
    req(8'h40, 8'h00, 16'h0003, 16'h0003, 16'h0, 0, 0);
    req(8'h40, 8'h00, 16'h0003, 16'h0410, 16'h0, 0, 0);
    check({uart_rx_en_o, uart_tx_en_o, fifo_rx_en_o[0], fifo_tx_en_o[0]}, 6'h17);
    req(8'h40, 8'h00, 16'h0002, 16'h0411, 16'h0, 0, 0);
    check({fifo_rx_en_o, fifo_tx_en_o}, 4'hD);
    req(8'hC0, 8'h01, 16'h0, 16'h0410, 16'h0002, 2, 2);
    check({i_host.rx_q[0], i_host.rx_q[1]}, 16'h0302);
    req(8'hC0, 8'h01, 16'h0, 16'h0003, 16'h0001, 1, 0);
    check(i_host.rx_q[0], 8'h03);
    req(8'hC0, 8'h01, 16'h0, 16'h0103, 16'h0001, 1, 0);
    check(i_host.rx_q[0], 8'h00);
    // every flush register, nonzero then zero
    foreach (fl[j]) begin
      req(8'h40, 8'h00, 16'h0080, {8'h04, fl[j]}, 16'h0, 0, 0);
      check(ev[3:0], 4'h1 << j);
      req(8'h40, 8'h00, 16'h0000, {8'h04, fl[j]}, 16'h0, 0, 0);
      check(ev[3:0], 4'h0);
    end
    req(8'h40, 8'h00, 16'h0005, 16'h6601, 16'h0, 0, 0);
    req(8'hC0, 8'h01, 16'h0, 16'h6601, 16'h0001, 1, 1);
    check(i_host.rx_q[0], 8'h05);
    req(8'h40, 8'h00, 16'h00A7, 16'h6512, 16'h0, 0, 0);
    req(8'hC0, 8'h01, 16'h0, 16'h6512, 16'h0001, 1, 0);
    check({ev[4], i_host.rx_q[0]}, 9'h15A);
    foreach (bad[j]) begin
      req(bad[j][31:24], bad[j][23:16], 16'h0, bad[j][15:0], 16'h0, 0, 0);
      check(ev[5:4], 2'b10);
    end
    // line coding: reset on a, 1200 baud on b
    req(8'hA1, 8'h21, 16'h0, 16'h0004, 16'h0007, 7, 0);
    foreach (lr[j]) check(i_host.rx_q[j], lr[j]);
    ev = '0;
    i_host.setup(8'h21, 8'h20, 16'h0, 16'h0002, 16'h0007);
    foreach (lc[j]) i_host.send(lc[j]);
    req(8'hA1, 8'h21, 16'h0, 16'h0006, 16'h0007, 7, 1);
    check(line_coding_o[1], {32'h0000_04B0, 8'h01, 8'h02, 8'h07});
    foreach (lc[j]) check(i_host.rx_q[j], lc[j]);
    req(8'h21, 8'h22, 16'h0002, 16'h0004, 16'h0, 0, 0);
    check(modem_ctrl_o[0], 2'b10);
    req(8'h21, 8'h23, 16'h1234, 16'h0002, 16'h0, 0, 0);
    check({ev[4], break_duration_o[1]}, 17'h11234);
    req(8'h00, 8'h03, 16'h0001, 16'h0, 16'h0, 0, 0);
    req(8'h80, 8'h00, 16'h0, 16'h0, 16'h0002, 2, 0);
    check({i_host.rx_q[1], i_host.rx_q[0]}, 16'h0003);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire

/* File: usb_ctrl_cfg.svh */
/*
  Constants of the endpoint-zero request interpreter.
  Assumes inclusion by bare name.
*/
`ifndef USB_CTRL_CFG_SVH
`define USB_CTRL_CFG_SVH

// request type bytes
`define RT_STD_DEV_IN 8'h80
`define RT_STD_IF_IN 8'h81
`define RT_STD_EP_IN 8'h82
`define RT_STD_DEV_OUT 8'h00
`define RT_STD_EP_OUT 8'h02
`define RT_CLASS_OUT 8'h21
`define RT_CLASS_IN 8'hA1
`define RT_VENDOR_OUT 8'h40
`define RT_VENDOR_IN 8'hC0

// request codes
`define RQ_GET_STATUS 8'h00
`define RQ_CLEAR_FEATURE 8'h01
`define RQ_SET_FEATURE 8'h03
`define RQ_SET_ADDRESS 8'h05
`define RQ_GET_CONFIGURATION 8'h08
`define RQ_SET_CONFIGURATION 8'h09
`define RQ_GET_INTERFACE 8'h0A
`define RQ_SET_LINE_CODING 8'h20
`define RQ_GET_LINE_CODING 8'h21
`define RQ_SET_CONTROL_LINES 8'h22
`define RQ_SEND_BREAK 8'h23
`define RQ_VENDOR_REGISTER_WRITE 8'h00
`define RQ_VENDOR_REGISTER_READ_BURST 8'h01

// feature selectors
`define FEAT_EP_HALT 16'h0000
`define FEAT_REMOTE_WAKE 16'h0001
`define FEAT_TEST_MODE 16'h0002

// register block numbers
`define BLK_CHANNEL_A 8'h00
`define BLK_CHANNEL_B 8'h01
`define BLK_MANAGER 8'h04
`define BLK_EEPROM 8'h65
`define BLK_CUSTOM 8'h66

// manager block offsets and fields
`define OFF_FIFO_ENABLE_CHANNEL_A 8'h10
`define OFF_FIFO_ENABLE_CHANNEL_B 8'h11
`define OFF_RX_FIFO_FLUSH_CHANNEL_A 8'h18
`define OFF_RX_FIFO_FLUSH_CHANNEL_B 8'h19
`define OFF_TX_FIFO_FLUSH_CHANNEL_A 8'h1C
`define OFF_TX_FIFO_FLUSH_CHANNEL_B 8'h1D
`define FIFO_EN_TX_BIT 0
`define FIFO_EN_RX_BIT 1

// channel uart enable
`define OFF_UART_ENABLE 5'h03
`define UART_EN_TX_BIT 0
`define UART_EN_RX_BIT 1

// custom block offsets and fields
`define OFF_CUSTOM_CHANNEL_A 8'h00
`define OFF_CUSTOM_CHANNEL_B 8'h01
`define CUS_WIDE_BIT 0
`define CUS_LOW_LATENCY_BIT 1
`define CUS_INT_PACKET_BIT 2

// reply lengths and line coding
`define LINE_CODING_LEN 16'h0007
`define STATUS_LEN 16'h0002
`define SINGLE_LEN 16'h0001
`define LOW_LATENCY_BAUD 32'd46921
`define LC_RESET_BAUD 32'h0000_2580
`define LC_RESET_STOP 8'h00
`define LC_RESET_PARITY 8'h00
`define LC_RESET_BITS 8'h08

`endif

/* File: usb_ctrl_chk.sv */
/*
  Concurrent checks on the request interpreter's ports.
  Assumes binding into usb_ctrl_regs, one clock, synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module usb_ctrl_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic setup_valid_i,
  input wire logic [7:0] request_type_i,
  input wire logic [7:0] request_i,
  input wire logic [15:0] value_i,
  input wire logic [15:0] index_i,
  input wire logic [15:0] length_i,
  input wire logic in_ready_i,
  input wire logic in_valid_o,
  input wire logic [7:0] in_data_o,
  input wire logic in_last_o,
  input wire logic status_ack_o,
  input wire logic stall_o,
  input wire logic [1:0] fifo_tx_en_o,
  input wire logic [1:0] fifo_rx_en_o,
  input wire logic [1:0] rx_flush_o,
  input wire logic [1:0] break_req_o,
  input wire logic [1:0][15:0] break_duration_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // setup phases
  sequence s_wr(ix);
    setup_valid_i && request_type_i == 8'h40 && request_i == 8'h00 && index_i == ix;
  endsequence
  sequence s_rd;
    setup_valid_i && request_type_i == 8'hC0 && request_i == 8'h01 && index_i[15:8] == 8'h04 && length_i != 16'h0;
  endsequence
  AST_WRITE_ACK: assert property (s_wr(16'h0410) |=> status_ack_o && !stall_o) else $error("write not acked");
  AST_READ_FIRST: assert property (s_rd |-> ##[2:3] in_valid_o) else $error("read reply late");
  AST_IN_HOLD: assert property (in_valid_o && !in_ready_i && !setup_valid_i |=>
    in_valid_o && $stable(in_data_o)) else $error("reply byte dropped");
  AST_LAST_ACK: assert property (in_valid_o && in_ready_i && in_last_o && !setup_valid_i |=>
    status_ack_o) else $error("no ack after last byte");
  AST_FIFO_EN: assert property (s_wr(16'h0410) |=>
    {fifo_rx_en_o[0], fifo_tx_en_o[0]} == ($past(value_i) & 16'h0003)) else $error("fifo enable");
  AST_EN_HOLD: assert property (!$past(setup_valid_i) |->
    $stable(fifo_tx_en_o) && $stable(fifo_rx_en_o)) else $error("fifo enable moved");
  AST_FLUSH_RX: assert property (s_wr(16'h0418) |=>
    rx_flush_o[0] == (($past(value_i) & 16'h00FF) != 16'h0000)) else $error("rx flush");
  AST_FLUSH_CAUSE: assert property (|rx_flush_o |-> $past(setup_valid_i)) else $error("stray flush");
  AST_BREAK: assert property (setup_valid_i && request_type_i == 8'h21 && request_i == 8'h23 &&
    index_i == 16'h0002 |=> break_req_o[1] && break_duration_o[1] == $past(value_i)) else $error("break");
  AST_STALL: assert property (s_wr(16'h0700) |=> stall_o && !status_ack_o) else $error("no stall");
endmodule // usb_ctrl_chk
bind usb_ctrl_regs usb_ctrl_chk i_usb_ctrl_chk (.clk_i, .rst_i, .setup_valid_i, .request_type_i, .request_i,
  .value_i, .index_i, .length_i, .in_ready_i, .in_valid_o, .in_data_o, .in_last_o, .status_ack_o, .stall_o,
  .fifo_tx_en_o, .fifo_rx_en_o, .rx_flush_o, .break_req_o, .break_duration_o);
`default_nettype wire

/* File: usb_ctrl_pkg.sv */
/*
  Types shared by the endpoint-zero request interpreter.
  Assumes usb_ctrl_cfg.svh is on the include path.
*/
`include "usb_ctrl_cfg.svh"

package usb_ctrl_pkg;

  // control transfer sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OUT = 3'b001,
    ST_FETCH = 3'b010,
    ST_WAIT = 3'b011,
    ST_SEND = 3'b100,
    ST_EE_WR = 3'b101
  } fsm_t;

  // one channel's line coding
  typedef struct packed {
    logic [31:0] baud;
    logic [7:0] stop;
    logic [7:0] parity;
    logic [7:0] bits;
  } line_coding_t;

endpackage

/* File: usb_ctrl_regs.sv */
/*
  Endpoint-zero request interpreter of a two-channel usb uart bridge.
  Assumes a same-clock usb engine gives setup fields and data bytes.
*/
// Function
// - Vendor write (0x40, 0) puts the value low byte at the indexed block and offset.
// - Vendor read (0xC0, 1) returns length consecutive registers.
// - Block 0 is channel A, block 1 channel B.
// - Block 4 is the manager with the fifo enables.
// - Block 0x65 goes out to the eeprom port.
// - Block 0x66 holds wide, low latency and interrupt packet enables.
// - Vendor requests are the register access; set line coding also sets the low latency bit below 46921 baud and clears it otherwise.
// - Manager 0x10/0x11 are fifo enables, bit 0 tx, bit 1 rx.
// - Nonzero writes to 0x18/0x19 (rx) or 0x1C/0x1D (tx) flush that fifo.
// - Set line coding (0x21, 32, 7 bytes) to interface 0/2/4/6 sets the format.
// - Get line coding (0xA1, 33) returns the 7 format bytes.
// - Set control lines (0x21, 34) drives the modem outputs.
// - Send break (0x21, 35) requests a break of the value duration.
// - Get status (0x80, 0) returns remote wakeup and self powered.
// - Uart enable bit 0 turns tx on, bit 1 rx.
`timescale 1ns/10ps
`default_nettype none
`include "usb_ctrl_cfg.svh"

module usb_ctrl_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic setup_valid_i,
  input wire logic [7:0] request_type_i,
  input wire logic [7:0] request_i,
  input wire logic [15:0] value_i,
  input wire logic [15:0] index_i,
  input wire logic [15:0] length_i,
  input wire logic out_valid_i,
  input wire logic [7:0] out_data_i,
  input wire logic in_ready_i,
  input wire logic self_powered_i,
  input wire logic ee_ack_i,
  input wire logic [7:0] ee_rdata_i,
  output logic in_valid_o,
  output logic [7:0] in_data_o,
  output logic in_last_o,
  output logic status_ack_o,
  output logic stall_o,
  output logic ee_req_o,
  output logic ee_we_o,
  output logic [7:0] ee_addr_o,
  output logic [7:0] ee_wdata_o,
  output logic [1:0] fifo_tx_en_o,
  output logic [1:0] fifo_rx_en_o,
  output logic [1:0] rx_flush_o,
  output logic [1:0] tx_flush_o,
  output logic [1:0] uart_tx_en_o,
  output logic [1:0] uart_rx_en_o,
  output usb_ctrl_pkg::line_coding_t [1:0] line_coding_o,
  output logic [1:0][1:0] modem_ctrl_o,
  output logic [1:0] break_req_o,
  output logic [1:0][15:0] break_duration_o,
  output logic [1:0] wide_mode_o,
  output logic [1:0] low_latency_o,
  output logic [1:0] int_packet_o,
  output logic remote_wake_en_o,
  output logic [6:0] usb_address_o,
  output logic [7:0] configuration_o,
  output logic [15:0] ep_halt_o,
  output logic [7:0] test_selector_o
);
  import usb_ctrl_pkg::*;

  localparam line_coding_t LC_RESET = '{`LC_RESET_BAUD, `LC_RESET_STOP, `LC_RESET_PARITY, `LC_RESET_BITS};

  typedef struct packed {
    fsm_t fsm;
    logic rd_reg;
    logic [7:0] blk;
    logic [7:0] off;
    logic [15:0] remain;
    logic [2:0] bidx;
    logic [6:0][7:0] rbuf;
    logic [7:0] in_data;
    logic in_valid;
    logic in_last;
    logic status_ack;
    logic stall;
    logic [2:0] out_cnt;
    logic out_ch;
    line_coding_t [1:0] lc;
    logic [1:0][1:0] fifo_en;
    logic [1:0] rx_flush;
    logic [1:0] tx_flush;
    logic [1:0][2:0] custom;
    logic [1:0][1:0] modem;
    logic [1:0] brk_req;
    logic [1:0][15:0] brk_dur;
    logic remote_wake;
    logic [6:0] usb_addr;
    logic [7:0] config_val;
    logic [15:0] ep_halt;
    logic [7:0] test_sel;
    logic ee_req;
    logic ee_we;
    logic [7:0] ee_addr;
    logic [7:0] ee_wdata;
    logic [1:0] cw_en;
    logic [4:0] cw_addr;
    logic [7:0] cw_data;
  } ctl_state_t;

  ctl_state_t q, d;
  logic [1:0][7:0] ch_rdata;
  logic [1:0] ch_tx_en;
  logic [1:0] ch_rx_en;

  // one register file per channel
  for (genvar c = 0; c < 2; c++) begin : g_chan
    chan_reg_file #(
      .ADDR_W(5)
    ) u_chan (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(q.cw_en[c]),
      .waddr_i(q.cw_addr),
      .wdata_i(q.cw_data),
      .raddr_i(q.off[4:0]),
      .rdata_o(ch_rdata[c]),
      .tx_en_o(ch_tx_en[c]),
      .rx_en_o(ch_rx_en[c])
    );
  end

  // request decode
  always_comb begin
    logic [15:0] rep_n;
    logic rep_go;
    logic ack_go;
    logic stall_go;
    logic ch;
    logic if_ok;
    logic [7:0] rbyte;
    line_coding_t lc_new;
    rep_n = 16'h0000;
    rep_go = 1'b0;
    ack_go = 1'b0;
    stall_go = 1'b0;
    ch = index_i[1];
    if_ok = (index_i[15:3] == 13'h0000) && !index_i[0];
    rbyte = 8'h00;
    lc_new = q.lc[q.out_ch];
    d = q;
    d.status_ack = 1'b0;
    d.stall = 1'b0;
    d.rx_flush = 2'b00;
    d.tx_flush = 2'b00;
    d.brk_req = 2'b00;
    d.cw_en = 2'b00;
    if (setup_valid_i) begin
      // a new setup aborts any transfer
      d.fsm = ST_IDLE;
      d.in_valid = 1'b0;
      d.in_last = 1'b0;
      d.ee_req = 1'b0;
      d.rbuf = '0;
      unique case ({request_type_i, request_i})
        {`RT_STD_DEV_IN, `RQ_GET_STATUS}: begin
          d.rbuf[0] = {6'h00, q.remote_wake, self_powered_i};
          rep_n = `STATUS_LEN;
          rep_go = 1'b1;
        end
        {`RT_STD_IF_IN, `RQ_GET_STATUS}: begin
          rep_n = `STATUS_LEN;
          rep_go = 1'b1;
        end
        {`RT_STD_EP_IN, `RQ_GET_STATUS}: begin
          d.rbuf[0] = {7'h00, q.ep_halt[{index_i[7], index_i[2:0]}]};
          rep_n = `STATUS_LEN;
          rep_go = 1'b1;
        end
        {`RT_STD_DEV_OUT, `RQ_CLEAR_FEATURE}, {`RT_STD_DEV_OUT, `RQ_SET_FEATURE}: begin
          if (value_i == `FEAT_REMOTE_WAKE) begin
            d.remote_wake = (request_i == `RQ_SET_FEATURE);
            ack_go = 1'b1;
          end else if (value_i == `FEAT_TEST_MODE && request_i == `RQ_SET_FEATURE) begin
            d.test_sel = index_i[15:8];
            ack_go = 1'b1;
          end else begin
            stall_go = 1'b1;
          end
        end
        {`RT_STD_EP_OUT, `RQ_CLEAR_FEATURE}, {`RT_STD_EP_OUT, `RQ_SET_FEATURE}: begin
          if (value_i == `FEAT_EP_HALT) begin
            d.ep_halt[{index_i[7], index_i[2:0]}] = (request_i == `RQ_SET_FEATURE);
            ack_go = 1'b1;
          end else begin
            stall_go = 1'b1;
          end
        end
        {`RT_STD_DEV_OUT, `RQ_SET_ADDRESS}: begin
          d.usb_addr = value_i[6:0];
          ack_go = 1'b1;
        end
        {`RT_STD_DEV_IN, `RQ_GET_CONFIGURATION}: begin
          d.rbuf[0] = q.config_val;
          rep_n = `SINGLE_LEN;
          rep_go = 1'b1;
        end
        {`RT_STD_DEV_OUT, `RQ_SET_CONFIGURATION}: begin
          d.config_val = value_i[7:0];
          ack_go = 1'b1;
        end
        {`RT_STD_IF_IN, `RQ_GET_INTERFACE}: begin
          rep_n = `SINGLE_LEN;
          rep_go = 1'b1;
        end
        {`RT_CLASS_OUT, `RQ_SET_LINE_CODING}: begin
          if (if_ok && length_i == `LINE_CODING_LEN) begin
            d.out_ch = ch;
            d.out_cnt = 3'h0;
            d.fsm = ST_OUT;
          end else begin
            stall_go = 1'b1;
          end
        end
        {`RT_CLASS_IN, `RQ_GET_LINE_CODING}: begin
          d.rbuf = {q.lc[ch].bits, q.lc[ch].parity, q.lc[ch].stop, q.lc[ch].baud[31:24],
                    q.lc[ch].baud[23:16], q.lc[ch].baud[15:8], q.lc[ch].baud[7:0]};
          rep_n = `LINE_CODING_LEN;
          rep_go = if_ok;
          stall_go = !if_ok;
        end
        {`RT_CLASS_OUT, `RQ_SET_CONTROL_LINES}: begin
          if (if_ok) begin
            d.modem[ch] = value_i[1:0];
          end
          ack_go = if_ok;
          stall_go = !if_ok;
        end
        {`RT_CLASS_OUT, `RQ_SEND_BREAK}: begin
          if (if_ok) begin
            d.brk_dur[ch] = value_i;
            d.brk_req[ch] = 1'b1;
          end
          ack_go = if_ok;
          stall_go = !if_ok;
        end
        {`RT_VENDOR_OUT, `RQ_VENDOR_REGISTER_WRITE}: begin
          ack_go = 1'b1;
          unique case (index_i[15:8])
            `BLK_CHANNEL_A, `BLK_CHANNEL_B: begin
              // offsets past the channel file are ignored
              d.cw_en[index_i[8]] = (index_i[7:5] == 3'h0);
              d.cw_addr = index_i[4:0];
              d.cw_data = value_i[7:0];
            end
            `BLK_MANAGER: begin
              unique case (index_i[7:0])
                `OFF_FIFO_ENABLE_CHANNEL_A: d.fifo_en[0] = value_i[1:0];
                `OFF_FIFO_ENABLE_CHANNEL_B: d.fifo_en[1] = value_i[1:0];
                `OFF_RX_FIFO_FLUSH_CHANNEL_A: d.rx_flush[0] = (value_i[7:0] != 8'h00);
                `OFF_RX_FIFO_FLUSH_CHANNEL_B: d.rx_flush[1] = (value_i[7:0] != 8'h00);
                `OFF_TX_FIFO_FLUSH_CHANNEL_A: d.tx_flush[0] = (value_i[7:0] != 8'h00);
                `OFF_TX_FIFO_FLUSH_CHANNEL_B: d.tx_flush[1] = (value_i[7:0] != 8'h00);
                default: ;
              endcase
            end
            `BLK_CUSTOM: begin
              if (index_i[7:1] == 7'h00) begin
                d.custom[index_i[0]] = value_i[2:0];
              end
            end
            `BLK_EEPROM: begin
              // ack waits for the eeprom port
              ack_go = 1'b0;
              d.ee_req = 1'b1;
              d.ee_we = 1'b1;
              d.ee_addr = index_i[7:0];
              d.ee_wdata = value_i[7:0];
              d.fsm = ST_EE_WR;
            end
            default: begin
              ack_go = 1'b0;
              stall_go = 1'b1;
            end
          endcase
        end
        {`RT_VENDOR_IN, `RQ_VENDOR_REGISTER_READ_BURST}: begin
          unique case (index_i[15:8])
            `BLK_CHANNEL_A, `BLK_CHANNEL_B, `BLK_MANAGER, `BLK_CUSTOM, `BLK_EEPROM: begin
              d.blk = index_i[15:8];
              d.off = index_i[7:0];
              rep_n = length_i;
              rep_go = 1'b1;
            end
            default: stall_go = 1'b1;
          endcase
        end
        default: stall_go = 1'b1;
      endcase
      // in stage, cut to host length
      if (rep_go) begin
        d.rd_reg = (request_type_i == `RT_VENDOR_IN);
        d.remain = (length_i < rep_n) ? length_i : rep_n;
        d.bidx = 3'h0;
        d.fsm = (d.remain == 16'h0000) ? ST_IDLE : ST_FETCH;
        ack_go = (d.remain == 16'h0000);
      end
      d.status_ack = ack_go;
      d.stall = stall_go;
    end else begin
      unique case (q.fsm)
        ST_IDLE: ;
        ST_OUT: begin
          // collect seven bytes
          if (out_valid_i) begin
            d.rbuf[q.out_cnt] = out_data_i;
            d.out_cnt = 3'(q.out_cnt + 3'h1);
            if (q.out_cnt == 3'h6) begin
              lc_new = '{{q.rbuf[3], q.rbuf[2], q.rbuf[1], q.rbuf[0]}, q.rbuf[4], q.rbuf[5], out_data_i};
              d.lc[q.out_ch] = lc_new;
              // slow rates would wait character times
              d.custom[q.out_ch][`CUS_LOW_LATENCY_BIT] = (lc_new.baud < `LOW_LATENCY_BAUD);
              d.status_ack = 1'b1;
              d.fsm = ST_IDLE;
            end
          end
        end
        ST_FETCH: begin
          if (q.rd_reg) begin
            d.ee_req = (q.blk == `BLK_EEPROM);
            d.ee_we = 1'b0;
            d.ee_addr = q.off;
            d.fsm = ST_WAIT;
          end else begin
            d.in_data = q.rbuf[q.bidx];
            d.in_valid = 1'b1;
            d.in_last = (q.remain == 16'h0001);
            d.fsm = ST_SEND;
          end
        end
        ST_WAIT: begin
          // channel data lags the offset a cycle
          unique case (q.blk)
            `BLK_CHANNEL_A, `BLK_CHANNEL_B: rbyte = (q.off[7:5] == 3'h0) ? ch_rdata[q.blk[0]] : 8'h00;
            `BLK_MANAGER: begin
              unique case (q.off)
                `OFF_FIFO_ENABLE_CHANNEL_A: rbyte = {6'h00, q.fifo_en[0]};
                `OFF_FIFO_ENABLE_CHANNEL_B: rbyte = {6'h00, q.fifo_en[1]};
                default: rbyte = 8'h00;
              endcase
            end
            `BLK_CUSTOM: rbyte = (q.off[7:1] == 7'h00) ? {5'h00, q.custom[q.off[0]]} : 8'h00;
            default: rbyte = ee_rdata_i;
          endcase
          if (q.blk != `BLK_EEPROM || ee_ack_i) begin
            d.ee_req = 1'b0;
            d.in_data = rbyte;
            d.in_valid = 1'b1;
            d.in_last = (q.remain == 16'h0001);
            d.fsm = ST_SEND;
          end
        end
        ST_SEND: begin
          if (in_ready_i) begin
            d.in_valid = 1'b0;
            d.in_last = 1'b0;
            d.remain = 16'(q.remain - 16'h0001);
            d.bidx = 3'(q.bidx + 3'h1);
            d.off = 8'(q.off + 8'h01);
            d.fsm = (q.remain == 16'h0001) ? ST_IDLE : ST_FETCH;
            d.status_ack = (q.remain == 16'h0001);
          end
        end
        ST_EE_WR: begin
          if (ee_ack_i) begin
            d.ee_req = 1'b0;
            d.status_ack = 1'b1;
            d.fsm = ST_IDLE;
          end
        end
        default: d.fsm = ST_IDLE;
      endcase
    end
  end

  // synchronous reset; line coding comes up at 9600 8N1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.lc <= {LC_RESET, LC_RESET};
    end else begin
      q <= d;
    end
  end

  // registered outputs
  assign in_valid_o = q.in_valid;
  assign in_data_o = q.in_data;
  assign in_last_o = q.in_last;
  assign status_ack_o = q.status_ack;
  assign stall_o = q.stall;
  assign ee_req_o = q.ee_req;
  assign ee_we_o = q.ee_we;
  assign ee_addr_o = q.ee_addr;
  assign ee_wdata_o = q.ee_wdata;
  assign fifo_tx_en_o = {q.fifo_en[1][`FIFO_EN_TX_BIT], q.fifo_en[0][`FIFO_EN_TX_BIT]};
  assign fifo_rx_en_o = {q.fifo_en[1][`FIFO_EN_RX_BIT], q.fifo_en[0][`FIFO_EN_RX_BIT]};
  assign rx_flush_o = q.rx_flush;
  assign tx_flush_o = q.tx_flush;
  assign uart_tx_en_o = ch_tx_en;
  assign uart_rx_en_o = ch_rx_en;
  assign line_coding_o = q.lc;
  assign modem_ctrl_o = q.modem;
  assign break_req_o = q.brk_req;
  assign break_duration_o = q.brk_dur;
  assign wide_mode_o = {q.custom[1][`CUS_WIDE_BIT], q.custom[0][`CUS_WIDE_BIT]};
  assign low_latency_o = {q.custom[1][`CUS_LOW_LATENCY_BIT], q.custom[0][`CUS_LOW_LATENCY_BIT]};
  assign int_packet_o = {q.custom[1][`CUS_INT_PACKET_BIT], q.custom[0][`CUS_INT_PACKET_BIT]};
  assign remote_wake_en_o = q.remote_wake;
  assign usb_address_o = q.usb_addr;
  assign configuration_o = q.config_val;
  assign ep_halt_o = q.ep_halt;
  assign test_selector_o = q.test_sel;

endmodule // usb_ctrl_regs

`default_nettype wire

/* File: usb_host_model.sv */
/*
  Host model: setups, data stage bytes, reply bytes.
  Assumes rising-edge sampling; this side moves on the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module usb_host_model (
  input wire logic clk_i,
  output logic setup_valid_o,
  output logic [7:0] request_type_o,
  output logic [7:0] request_o,
  output logic [15:0] value_o,
  output logic [15:0] index_o,
  output logic [15:0] length_o,
  output logic out_valid_o,
  output logic [7:0] out_data_o,
  output logic in_ready_o,
  input wire logic in_valid_i,
  input wire logic [7:0] in_data_i
);
  logic [7:0] rx_q [8];
  initial begin
    {setup_valid_o, request_type_o, request_o, value_o, index_o, length_o, out_valid_o, out_data_o} = '0;
    in_ready_o = 1'b0;
  end
  // setup pulse; fields then inverted
  task automatic setup(input logic [7:0] t, r, input logic [15:0] v, i, l);
    @(negedge clk_i);
    {setup_valid_o, request_type_o, request_o, value_o, index_o, length_o} = {1'b1, t, r, v, i, l};
    @(negedge clk_i);
    setup_valid_o = 1'b0;
    {request_type_o, request_o, value_o, index_o, length_o} = ~{t, r, v, i, l};
  endtask
  // one data stage byte
  task automatic send(input logic [7:0] b);
    @(negedge clk_i);
    {out_valid_o, out_data_o} = {1'b1, b};
    @(negedge clk_i);
    {out_valid_o, out_data_o} = {1'b0, ~b};
  endtask
  // take n bytes, s idle cycles before each
  task automatic take(input int n, input int s);
    int k;
    for (int b = 0; b < n; b++) begin
      k = 0;
      repeat (s) @(negedge clk_i);
      while (in_valid_i !== 1'b1 && k < 20) begin
        @(negedge clk_i);
        k++;
      end
      rx_q[b] = in_data_i;
      in_ready_o = 1'b1;
      @(negedge clk_i);
      in_ready_o = 1'b0;
    end
  endtask
endmodule // usb_host_model
`default_nettype wire
